// *** rtl/xgmii_port_pkg.sv ***
/*
 * Constants shared by the MAC-facing parallel port: line rate codes,
 * valid cadence periods, widths and latency report layout.
 * Assumes it is compiled before every other design file.
 */
package xgmii_port_pkg;

	// ============================================================
	// Line rate codes presented to the MAC
	localparam logic [2:0] RATE_10G  = 3'h0;
	localparam logic [2:0] RATE_1G   = 3'h1;
	localparam logic [2:0] RATE_100M = 3'h2;
	localparam logic [2:0] RATE_10M  = 3'h3;
	localparam logic [2:0] RATE_2G5  = 3'h4;
	localparam logic [2:0] RATE_5G   = 3'h5;

	// ============================================================
	// Core clock cycles per valid word at each rate
	localparam int          CAD_W      = 10;
	localparam logic [9:0]  PER_10M    = 10'h3E8;
	localparam logic [9:0]  PER_100M   = 10'h064;
	localparam logic [9:0]  PER_1G     = 10'h00A;
	localparam logic [9:0]  PER_2G5    = 10'h004;
	localparam logic [9:0]  PER_5G     = 10'h002;
	localparam logic [9:0]  PER_10G    = 10'h001;
	localparam logic [9:0]  CAD_ONE    = 10'h001;
	localparam logic [9:0]  CAD_ZERO   = 10'h000;
	localparam logic [9:0]  GAP_MAX    = 10'h3FF;

	// ============================================================
	// Bus widths
	localparam int WIDE_DATA_W   = 64;
	localparam int NARROW_DATA_W = 32;
	localparam int LANE_W        = 8;

	// ============================================================
	// Latency report: fixed point, fraction in the low bits
	localparam int LAT_FRAC_W   = 10;
	localparam int LAT_WIDE_W   = 16;
	localparam int LAT_NARROW_W = 24;
	localparam int TX_PIPE_CYC  = 1;
	localparam int RX_OUT_CYC   = 1;

	// ============================================================
	// Nominal core clock for 10G operation, in kHz
	localparam int CORE_10G_KHZ = 156250;

	// ============================================================
	// Fifo depth in the receive path
	localparam int RX_FIFO_DEPTH = 8;

endpackage

// *** rtl/word_fifo.sv ***
/*
 * Synchronous word fifo with valid/ready on both sides and an occupancy count.
 * Assumes one clock and an asynchronous active-low reset.
 */
module word_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 8,
	parameter int CNT_W = $clog2(DEPTH + 1)
) (
	// Clock and reset
	input  wire logic             sys_clk_i,
	input  wire logic             nrst_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o,
	// Occupancy
	output logic [CNT_W-1:0]      count_o
);

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PTR_W-1:0] wr_ptr_r;
	logic [PTR_W-1:0] wr_ptr_nxt;
	logic [PTR_W-1:0] rd_ptr_r;
	logic [PTR_W-1:0] rd_ptr_nxt;
	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] count_nxt;
	logic             push;
	logic             pop;

	// ============================================================
	// Handshakes
	assign in_ready_o  = (count_r != FULL_CNT);
	assign out_valid_o = (count_r != '0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem_r[rd_ptr_r];
	assign count_o     = count_r;

	// ============================================================
	// Pointers and count
	always_comb
	begin
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		count_nxt  = count_r;
		if (push)
			wr_ptr_nxt = (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + PTR_W'(1);
		if (pop)
			rd_ptr_nxt = (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + PTR_W'(1);
		if (push && !pop)
			count_nxt = count_r + CNT_W'(1);
		else if (pop && !push)
			count_nxt = count_r - CNT_W'(1);
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else
		begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r  <= count_nxt;
		end
	end

	// Storage carries no reset; only written words are ever read.
	always_ff @(posedge sys_clk_i)
	begin
		if (push)
			mem_r[wr_ptr_r] <= in_data_i;
	end

endmodule

// *** rtl/xgmii_mac_port.sv ***
/*
 * MAC-facing parallel data port of a multi-rate PHY: transmit words from the
 * MAC go to the coding logic, receive words from the coding logic are
 * buffered and handed to the MAC at the cadence of the current line rate,
 * with optional fixed-point latency reports for time stamping.
 * Assumes the coding logic and the MAC share sys_clk_i, which stands for
 * both the transmit and the receive core clock in this build.
 */
// Functional notes
// - Receive data: first octet in lowest lane
// - One receive control bit per byte lane
// - Receive valid once every rate-dependent N cycles
// - Transmit latency report, ten fraction bits
// - Latency reports exist only with time stamping
// - Each direction timed by its core clock
// - 10G runs at 156.25 MHz core clock
// - Three-bit current line rate output
module xgmii_mac_port #(
	parameter int DATA_W     = xgmii_port_pkg::NARROW_DATA_W,
	parameter int LAT_W      = xgmii_port_pkg::LAT_NARROW_W,
	parameter int FIFO_DEPTH = xgmii_port_pkg::RX_FIFO_DEPTH,
	parameter bit ENABLE_PTP = 1'b1,
	parameter int RX_BASE    = 2
) (
	// Clock and reset
	input  wire logic                    sys_clk_i,
	input  wire logic                    nrst_i,
	// Transmit from the MAC
	input  wire logic [DATA_W-1:0]       tx_data_i,
	input  wire logic [DATA_W/8-1:0]     tx_ctrl_i,
	input  wire logic                    tx_valid_i,
	// Transmit toward the coding logic
	output logic [DATA_W-1:0]            pcs_tx_data_o,
	output logic [DATA_W/8-1:0]          pcs_tx_ctrl_o,
	output logic                         pcs_tx_valid_o,
	// Receive from the coding logic
	input  wire logic [DATA_W-1:0]       pcs_rx_data_i,
	input  wire logic [DATA_W/8-1:0]     pcs_rx_ctrl_i,
	input  wire logic                    pcs_rx_valid_i,
	output logic                         pcs_rx_ready_o,
	input  wire logic [9:0]              pcs_rx_frac_i,
	input  wire logic [2:0]              line_rate_i,
	// Receive toward the MAC
	output logic [DATA_W-1:0]            rx_data_o,
	output logic [DATA_W/8-1:0]          rx_ctrl_o,
	output logic                         rx_valid_o,
	output logic [2:0]                   rate_o,
	// Latency reports
	output logic [LAT_W-1:0]             tx_latency_o,
	output logic [LAT_W-1:0]             rx_latency_o
);

	localparam int CTRL_W  = DATA_W / xgmii_port_pkg::LANE_W;
	localparam int WORD_W  = DATA_W + CTRL_W;
	localparam int CNT_W   = $clog2(FIFO_DEPTH + 1);
	localparam int WHOLE_W = LAT_W - xgmii_port_pkg::LAT_FRAC_W;
	localparam int FRAC_W  = xgmii_port_pkg::LAT_FRAC_W;
	localparam int PER_W   = xgmii_port_pkg::CAD_W;

	// ============================================================
	// Rate to cadence period
	function automatic logic [9:0] rate_period(input logic [2:0] rate);
		logic [9:0] per;
		per = xgmii_port_pkg::PER_10G;
		if (rate == xgmii_port_pkg::RATE_10M)
			per = xgmii_port_pkg::PER_10M;
		else if (rate == xgmii_port_pkg::RATE_100M)
			per = xgmii_port_pkg::PER_100M;
		else if (rate == xgmii_port_pkg::RATE_1G)
			per = xgmii_port_pkg::PER_1G;
		else if (rate == xgmii_port_pkg::RATE_2G5)
			per = xgmii_port_pkg::PER_2G5;
		else if (rate == xgmii_port_pkg::RATE_5G)
			per = xgmii_port_pkg::PER_5G;
		return per;
	endfunction

	// ============================================================
	// Transmit path
	// Control bit i travels with lane i untouched; lane order is kept as given.
	logic [DATA_W-1:0] ptx_data_r;
	logic [DATA_W-1:0] ptx_data_nxt;
	logic [CTRL_W-1:0] ptx_ctrl_r;
	logic [CTRL_W-1:0] ptx_ctrl_nxt;
	logic              ptx_valid_r;
	logic              ptx_valid_nxt;

	always_comb
	begin
		ptx_data_nxt  = ptx_data_r;
		ptx_ctrl_nxt  = ptx_ctrl_r;
		ptx_valid_nxt = tx_valid_i;
		if (tx_valid_i)
		begin
			ptx_data_nxt = tx_data_i;
			ptx_ctrl_nxt = tx_ctrl_i;
		end
	end

	// Both directions sample and drive on the core clock edge only.
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ptx_data_r  <= '0;
			ptx_ctrl_r  <= '0;
			ptx_valid_r <= 1'b0;
		end
		else
		begin
			ptx_data_r  <= ptx_data_nxt;
			ptx_ctrl_r  <= ptx_ctrl_nxt;
			ptx_valid_r <= ptx_valid_nxt;
		end
	end

	assign pcs_tx_data_o  = ptx_data_r;
	assign pcs_tx_ctrl_o  = ptx_ctrl_r;
	assign pcs_tx_valid_o = ptx_valid_r;

	// ============================================================
	// Rate tracking and receive cadence
	// A rate change restarts the cadence, so the gap around it is irregular.
	logic [2:0]       rate_r;
	logic [2:0]       rate_nxt;
	logic [PER_W-1:0] cad_r;
	logic [PER_W-1:0] cad_nxt;
	logic             tick;

	assign tick = (cad_r == xgmii_port_pkg::CAD_ZERO) && (rate_r == line_rate_i);

	always_comb
	begin
		rate_nxt = line_rate_i;
		if (rate_r != line_rate_i)
			cad_nxt = rate_period(line_rate_i) - xgmii_port_pkg::CAD_ONE;
		else if (tick)
			cad_nxt = rate_period(rate_r) - xgmii_port_pkg::CAD_ONE;
		else
			cad_nxt = cad_r - xgmii_port_pkg::CAD_ONE;
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rate_r <= xgmii_port_pkg::RATE_10G;
			cad_r  <= xgmii_port_pkg::CAD_ZERO;
		end
		else
		begin
			rate_r <= rate_nxt;
			cad_r  <= cad_nxt;
		end
	end

	assign rate_o = rate_r;

	// ============================================================
	// Receive buffer and output stage
	logic [WORD_W-1:0] fifo_out;
	logic              fifo_valid;
	logic              pop;
	logic [CNT_W-1:0]  fifo_cnt;

	word_fifo #(.WIDTH (WORD_W), .DEPTH (FIFO_DEPTH)) u_rx_fifo (
		.sys_clk_i   (sys_clk_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (pcs_rx_valid_i),
		.in_ready_o  (pcs_rx_ready_o),
		.in_data_i   ({pcs_rx_ctrl_i, pcs_rx_data_i}),
		.out_valid_o (fifo_valid),
		.out_ready_i (tick),
		.out_data_o  (fifo_out),
		.count_o     (fifo_cnt)
	);

	// An empty buffer at a cadence slot skips that slot rather than stalling.
	assign pop = tick && fifo_valid;

	logic [DATA_W-1:0] rxd_r;
	logic [DATA_W-1:0] rxd_nxt;
	logic [CTRL_W-1:0] rxc_r;
	logic [CTRL_W-1:0] rxc_nxt;
	logic              rxv_r;
	logic              rxv_nxt;

	always_comb
	begin
		rxd_nxt = rxd_r;
		rxc_nxt = rxc_r;
		rxv_nxt = pop;
		if (pop)
		begin
			rxd_nxt = fifo_out[DATA_W-1:0];
			rxc_nxt = fifo_out[WORD_W-1:DATA_W];
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rxd_r <= '0;
			rxc_r <= '0;
			rxv_r <= 1'b0;
		end
		else
		begin
			rxd_r <= rxd_nxt;
			rxc_r <= rxc_nxt;
			rxv_r <= rxv_nxt;
		end
	end

	assign rx_data_o  = rxd_r;
	assign rx_ctrl_o  = rxc_r;
	assign rx_valid_o = rxv_r;

	// ============================================================
	// Latency reports
	// The transmit figure is a fixed pipeline; the receive figure follows the
	// buffer fill. Consumers must discard early values after start-up.
	logic [LAT_W-1:0] txl_r;
	logic [LAT_W-1:0] txl_nxt;
	logic [LAT_W-1:0] rxl_r;
	logic [LAT_W-1:0] rxl_nxt;

	always_comb
	begin
		txl_nxt = '0;
		rxl_nxt = '0;
		if (ENABLE_PTP)
		begin
			txl_nxt = {WHOLE_W'(xgmii_port_pkg::TX_PIPE_CYC), FRAC_W'(0)};
			rxl_nxt = {WHOLE_W'(RX_BASE + xgmii_port_pkg::RX_OUT_CYC) + WHOLE_W'(fifo_cnt),
				pcs_rx_frac_i};
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			txl_r <= '0;
			rxl_r <= '0;
		end
		else
		begin
			txl_r <= txl_nxt;
			rxl_r <= rxl_nxt;
		end
	end

	assign tx_latency_o = txl_r;
	assign rx_latency_o = rxl_r;

	// ============================================================
	// Checks
	logic [PER_W-1:0] gap_r;
	logic             steady_r;

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			gap_r    <= xgmii_port_pkg::GAP_MAX;
			steady_r <= 1'b0;
		end
		else
		begin
			if (rxv_r)
				gap_r <= xgmii_port_pkg::CAD_ONE;
			else if (gap_r != xgmii_port_pkg::GAP_MAX)
				gap_r <= gap_r + xgmii_port_pkg::CAD_ONE;
			if (rxv_r)
				steady_r <= 1'b1;
			else if (rate_r != line_rate_i)
				steady_r <= 1'b0;
		end
	end

	sequence s_rx_slot;
		tick && fifo_valid;
	endsequence
	sequence s_rx_word(logic [WORD_W-1:0] w);
		rx_valid_o && ({rx_ctrl_o, rx_data_o} == w);
	endsequence

	a_rx_gap_min: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(rx_valid_o && steady_r && (rate_r == line_rate_i)) |-> (gap_r >= rate_period(rate_r)))
	else $error("receive valid came before its cadence period");
	a_rx_10g_each: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		((rate_r == xgmii_port_pkg::RATE_10G) && (line_rate_i == xgmii_port_pkg::RATE_10G)
			&& fifo_valid) |-> tick)
	else $error("10G cadence missed a slot with data waiting");
	a_rx_word_order: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		s_rx_slot |=> s_rx_word($past(fifo_out)))
	else $error("receive word or lane order corrupted");
	a_rx_ctrl_lane: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		pop |=> (rx_ctrl_o == $past(fifo_out[WORD_W-1:DATA_W])))
	else $error("receive control bits not paired with their lanes");
	a_rx_no_spurious: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		rx_valid_o |-> $past(tick) && $past(fifo_valid))
	else $error("receive valid without a filled slot");
	a_tx_pass_thru: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		tx_valid_i |=> pcs_tx_valid_o && (pcs_tx_data_o == $past(tx_data_i))
			&& (pcs_tx_ctrl_o == $past(tx_ctrl_i)))
	else $error("transmit word not forwarded intact");
	a_rate_follow: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		$changed(line_rate_i) |=> (rate_o == $past(line_rate_i)) && !rx_valid_o)
	else $error("line rate output or cadence restart wrong");
	a_lat_format: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		ENABLE_PTP |=> (rx_latency_o[FRAC_W-1:0] == $past(pcs_rx_frac_i))
			&& (tx_latency_o[FRAC_W-1:0] == '0))
	else $error("latency fraction field wrong");
	a_lat_absent: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		!ENABLE_PTP |-> (tx_latency_o == '0) && (rx_latency_o == '0))
	else $error("latency reported without time stamping");

	// The 10G core clock is nominally this rate; slower rates use the cadence.
	localparam int NOMINAL_KHZ = xgmii_port_pkg::CORE_10G_KHZ;

endmodule

// *** verification/mac_model.sv ***
/*
 * Behavioural MAC: sends transmit words at the cadence of its period and
 * counts the receive words it is handed.
 * Assumes the bench's clock; inputs change just after the rising edge.
 */
module mac_model
(
	// Clock and reset
	input  wire logic   sys_clk_i,
	input  wire logic   nrst_i,
	// Pacing from the bench
	input  wire logic   run_i,
	input  int          period_i,
	// Transmit toward the port
	output logic [31:0] tx_data_o,
	output logic [3:0]  tx_ctrl_o,
	output logic        tx_valid_o,
	// Receive from the port
	input  wire logic   rx_valid_i,
	output int          rx_cnt_o,
	output logic        lat_ok_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int   cad = 0;
	int   seq = 0;
	logic go;

	// Time stamps are not trusted before three minimum packets have left.
	assign lat_ok_o = (seq >= 48);

	initial
	begin
		tx_valid_o = 1'b0;
		tx_data_o = 32'h0;
		tx_ctrl_o = 4'h0;
		rx_cnt_o = 0;
	end

	always @(posedge sys_clk_i)
	begin
		go = run_i && nrst_i;
		if (nrst_i && rx_valid_i)
			rx_cnt_o++;
		#1;
		tx_valid_o = go && (cad == 0);
		cad = !go ? 0 : ((cad == 0) ? period_i - 1 : cad - 1);
		if (tx_valid_o)
		begin
			tx_data_o = {8'(4*seq+3), 8'(4*seq+2), 8'(4*seq+1), 8'(4*seq)};
			tx_ctrl_o = 4'(seq);
			seq++;
		end
		else
		begin
			// Idle lines must not keep looking like the last word.
			tx_data_o = ~tx_data_o;
			tx_ctrl_o = ~tx_ctrl_o;
		end
	end
endmodule

// *** verification/multirate_phy_xgmii_mac_port_tb.sv ***
/*
 * Bench for the MAC-facing port: a MAC model drives transmit, the bench
 * plays the coding logic on receive.
 * Assumes the design package and fifo are compiled first.
 */
module multirate_phy_xgmii_mac_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int RXB = 2;
	logic        sys_clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [31:0] tx_data_i, pcs_tx_data_o, rx_data_o;
	logic [31:0] pcs_rx_data_i = 32'h0;
	logic [3:0]  tx_ctrl_i, pcs_tx_ctrl_o, rx_ctrl_o;
	logic [3:0]  pcs_rx_ctrl_i = 4'h0;
	logic        tx_valid_i, pcs_tx_valid_o, pcs_rx_ready_o, rx_valid_o, lat_ok;
	logic        pcs_rx_valid_i = 1'b0;
	logic        run = 1'b0;
	logic [9:0]  pcs_rx_frac_i = 10'h2A5;
	logic [2:0]  line_rate_i = xgmii_port_pkg::RATE_10G;
	logic [2:0]  rate_o;
	logic [23:0] tx_latency_o, rx_latency_o, tx_lat2, rx_lat2;
	logic        tx_v_d = 1'b0;
	int          mac_per = 1;
	int          mac_cnt, cyc = 0, rx_idx = 0, tx_idx = 0, wr_idx = 0;
	int          error_cnt = 0, n_tests = 0;
	int          q_rx[$], q_tx[$];
	logic [2:0]  rt [5] = '{xgmii_port_pkg::RATE_10G, xgmii_port_pkg::RATE_5G,
		xgmii_port_pkg::RATE_2G5, xgmii_port_pkg::RATE_1G, xgmii_port_pkg::RATE_100M};
	int          pr [5] = '{1, 2, 4, 10, 100};

	always #12.5 sys_clk_i = ~sys_clk_i;

	xgmii_mac_port #(.RX_BASE(RXB)) DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
		.tx_data_i(tx_data_i), .tx_ctrl_i(tx_ctrl_i), .tx_valid_i(tx_valid_i),
		.pcs_tx_data_o(pcs_tx_data_o), .pcs_tx_ctrl_o(pcs_tx_ctrl_o),
		.pcs_tx_valid_o(pcs_tx_valid_o), .pcs_rx_data_i(pcs_rx_data_i),
		.pcs_rx_ctrl_i(pcs_rx_ctrl_i), .pcs_rx_valid_i(pcs_rx_valid_i),
		.pcs_rx_ready_o(pcs_rx_ready_o), .pcs_rx_frac_i(pcs_rx_frac_i),
		.line_rate_i(line_rate_i), .rx_data_o(rx_data_o), .rx_ctrl_o(rx_ctrl_o),
		.rx_valid_o(rx_valid_o), .rate_o(rate_o), .tx_latency_o(tx_latency_o),
		.rx_latency_o(rx_latency_o));

	// Same traffic without time stamping; only its latency ports are watched.
	xgmii_mac_port #(.RX_BASE(RXB), .ENABLE_PTP(1'b0)) DUT2 (.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i), .tx_data_i(tx_data_i), .tx_ctrl_i(tx_ctrl_i),
		.tx_valid_i(tx_valid_i), .pcs_tx_data_o(), .pcs_tx_ctrl_o(), .pcs_tx_valid_o(),
		.pcs_rx_data_i(pcs_rx_data_i), .pcs_rx_ctrl_i(pcs_rx_ctrl_i),
		.pcs_rx_valid_i(pcs_rx_valid_i), .pcs_rx_ready_o(), .pcs_rx_frac_i(pcs_rx_frac_i),
		.line_rate_i(line_rate_i), .rx_data_o(), .rx_ctrl_o(), .rx_valid_o(), .rate_o(),
		.tx_latency_o(tx_lat2), .rx_latency_o(rx_lat2));

	mac_model MAC (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .run_i(run), .period_i(mac_per),
		.tx_data_o(tx_data_i), .tx_ctrl_o(tx_ctrl_i), .tx_valid_o(tx_valid_i),
		.rx_valid_i(rx_valid_o), .rx_cnt_o(mac_cnt), .lat_ok_o(lat_ok));

	function automatic logic [31:0] word(input int j);
		return {8'(4*j+3), 8'(4*j+2), 8'(4*j+1), 8'(4*j)};
	endfunction

	function automatic int miss(input logic [63:0] got, input logic [63:0] exp);
		$display("Error at %0t ns: got %h, expected %h", $time, got, exp);
		return 1;
	endfunction

	// ============================================================
	// Monitors
	always @(posedge sys_clk_i)
	begin
		cyc <= cyc + 1;
		tx_v_d <= tx_valid_i;
		if (nrst_i && rx_valid_o)
		begin
			q_rx.push_back(cyc);
			n_tests++;
			if ({rx_ctrl_o, rx_data_o} !== {4'(rx_idx), word(rx_idx)})
				error_cnt += miss(64'({rx_ctrl_o, rx_data_o}), 64'({4'(rx_idx), word(rx_idx)}));
			rx_idx++;
		end
		if (nrst_i && pcs_tx_valid_o)
		begin
			q_tx.push_back(cyc);
			n_tests++;
			if ({tx_v_d, pcs_tx_ctrl_o, pcs_tx_data_o}
				!== {1'b1, 4'(tx_idx), word(tx_idx)})
				error_cnt += miss(64'({tx_v_d, pcs_tx_ctrl_o, pcs_tx_data_o}),
					64'({1'b1, 4'(tx_idx), word(tx_idx)}));
			tx_idx++;
		end
	end

	// ============================================================
	// Shared tasks
	task automatic wrap_up();
		if (error_cnt == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic push();
		int b;
		b = 0;
		pcs_rx_data_i = word(wr_idx);
		pcs_rx_ctrl_i = 4'(wr_idx);
		pcs_rx_valid_i = 1'b1;
		while (pcs_rx_ready_o !== 1'b1 && b < 20000)
		begin
			@(posedge sys_clk_i);
			#1;
			b++;
		end
		if (b >= 20000)
		begin
			error_cnt++;
			wrap_up();
		end
		@(posedge sys_clk_i);
		#1;
		wr_idx++;
	endtask

	task automatic idle();
		pcs_rx_valid_i = 1'b0;
		pcs_rx_data_i = ~pcs_rx_data_i;
		pcs_rx_ctrl_i = ~pcs_rx_ctrl_i;
	endtask

	task automatic wait_rx(input int n, input int b);
		int c;
		c = 0;
		while (q_rx.size() < n && c < b)
		begin
			@(posedge sys_clk_i);
			#1;
			c++;
		end
		if (q_rx.size() < n)
		begin
			error_cnt++;
			wrap_up();
		end
	endtask

	task automatic chk_gap(ref int q[$], input int p);
		for (int k = 1; k < q.size(); k++)
		begin
			n_tests++;
			if (q[k] - q[k-1] !== p)
				error_cnt += miss(64'(q[k] - q[k-1]), 64'(p));
		end
	endtask

	// ============================================================
	// Scenarios
	task automatic chk_reset();
		n_tests++;
		if ({pcs_rx_ready_o, rx_valid_o, pcs_tx_valid_o, rate_o, tx_latency_o}
			!== 30'h20000000)
			error_cnt += miss(64'({pcs_rx_ready_o, rx_valid_o, pcs_tx_valid_o, rate_o,
				tx_latency_o}), 64'h20000000);
	endtask

	task automatic tx_cadence();
		mac_per = 4;
		run = 1'b1;
		repeat (200) @(posedge sys_clk_i);
		#1;
		run = 1'b0;
		repeat (3) @(posedge sys_clk_i);
		#1;
		chk_gap(q_tx, 4);
		n_tests++;
		if (q_tx.size() < 49 || lat_ok !== 1'b1)
			error_cnt += miss(64'(q_tx.size()), 64'h31);
		n_tests++;
		if (tx_latency_o !== {14'(xgmii_port_pkg::TX_PIPE_CYC), 10'h000})
			error_cnt += miss(64'(tx_latency_o), 64'(xgmii_port_pkg::TX_PIPE_CYC) << 10);
	endtask

	task automatic rx_rates();
		for (int k = 0; k < 5; k++)
		begin
			line_rate_i = rt[k];
			repeat (2) @(posedge sys_clk_i);
			#1;
			n_tests++;
			if (rate_o !== rt[k])
				error_cnt += miss(64'(rate_o), 64'(rt[k]));
			q_rx.delete();
			for (int j = 0; j < 4; j++)
				push();
			idle();
			wait_rx(4, 4 * pr[k] + 40);
			chk_gap(q_rx, pr[k]);
		end
	endtask

	task automatic rx_full();
		line_rate_i = xgmii_port_pkg::RATE_10M;
		repeat (2) @(posedge sys_clk_i);
		#1;
		q_rx.delete();
		for (int j = 0; j < 8; j++)
			push();
		repeat (3) @(posedge sys_clk_i);
		#1;
		n_tests++;
		if ({pcs_rx_ready_o, rx_latency_o} !== {1'b0, 14'(RXB + 9), pcs_rx_frac_i})
			error_cnt += miss(64'({pcs_rx_ready_o, rx_latency_o}),
				64'({1'b0, 14'(RXB + 9), pcs_rx_frac_i}));
		push();
		idle();
		wait_rx(9, 10500);
		chk_gap(q_rx, 1000);
		repeat (3) @(posedge sys_clk_i);
		#1;
		n_tests++;
		if (rx_latency_o !== {14'(RXB + 1), pcs_rx_frac_i})
			error_cnt += miss(64'(rx_latency_o), 64'({14'(RXB + 1), pcs_rx_frac_i}));
		n_tests++;
		if (mac_cnt != wr_idx)
			error_cnt += miss(64'(mac_cnt), 64'(wr_idx));
		n_tests++;
		if ({tx_lat2, rx_lat2} !== 48'h0)
			error_cnt += miss(64'({tx_lat2, rx_lat2}), 64'h0);
	endtask

	initial
	begin
		repeat (16) @(posedge sys_clk_i);
		#1;
		chk_reset();
		nrst_i = 1'b1;
		tx_cadence();
		rx_rates();
		rx_full();
		wrap_up();
	end
endmodule
